// ===== hw/puc_pkg.sv
// Shared constants and types of the presettable up/down counter.
`default_nettype none
package puc_pkg;

  // ----------------------------------------------------------------
  // Count widths and limits
  // ----------------------------------------------------------------
  localparam int unsigned COUNT_W = 4;
  localparam logic [3:0] BINARY_MAX = 4'hf;
  localparam logic [3:0] DECADE_MAX = 4'h9;
  localparam logic [3:0] COUNT_MIN = 4'h0;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
  localparam int unsigned ADDR_DEC_W = 8;

  // Control register fields and reset values.
  localparam int unsigned CTRL_DIR_UP_BIT = 0;
  localparam int unsigned CTRL_BINARY_BIT = 1;
  localparam logic CTRL_DIR_UP_RST = 1'b1;
  localparam logic CTRL_BINARY_RST = 1'b1;

  // Status register fields.
  localparam int unsigned STATUS_COUNT_LSB = 0;
  localparam int unsigned STATUS_CARRY_BIT = 4;
  localparam int unsigned STATUS_PRESET_BIT = 5;
  localparam int unsigned STATUS_INHIBIT_BIT = 6;

  // ----------------------------------------------------------------
  // Bus encodings and slave states
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'h0,
    BUS_WRITE = 2'h1,
    BUS_READ  = 2'h3
  } puc_bus_e;

  typedef enum logic [1:0] {
    SEL_NONE   = 2'h0,
    SEL_CTRL   = 2'h1,
    SEL_STATUS = 2'h2
  } puc_sel_e;

endpackage
`default_nettype wire

// ===== hw/puc_step_if.sv
// Carrier between the counter core and its step and carry logic.
`default_nettype none
interface puc_step_if;
  logic [3:0] count;
  logic       dirUp;
  logic       radixBinary;
  logic       countInhibit;
  logic [3:0] nextCount;
  logic       carryOutN;

  modport core (output count, output dirUp, output radixBinary, output countInhibit,
                input nextCount, input carryOutN);
  modport step (input count, input dirUp, input radixBinary, input countInhibit,
                output nextCount, output carryOutN);
endinterface
`default_nettype wire

// ===== hw/puc_step.sv
// Step and look-ahead carry logic of the up/down counter.
`default_nettype none
module puc_step (
  puc_step_if.step stepIf
);

  logic [3:0] maxCount;
  logic       atTerminal;

  // ----------------------------------------------------------------
  // Range and next value
  // ----------------------------------------------------------------
  always_comb begin
    maxCount = stepIf.radixBinary ? puc_pkg::BINARY_MAX : puc_pkg::DECADE_MAX;
  end

  always_comb begin
    if (stepIf.dirUp) begin
      // An out-of-range decade value restarts at zero so the digit stays BCD.
      if (stepIf.count >= maxCount) begin
        stepIf.nextCount = puc_pkg::COUNT_MIN;
      end else begin
        stepIf.nextCount = 4'(stepIf.count + 4'h1);
      end
    end else begin
      if (stepIf.count == puc_pkg::COUNT_MIN || stepIf.count > maxCount) begin
        stepIf.nextCount = maxCount;
      end else begin
        stepIf.nextCount = 4'(stepIf.count - 4'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Look-ahead carry
  // ----------------------------------------------------------------
  // Purely combinational so a cascaded stage sees it before the shared clock edge.
  always_comb begin
    atTerminal = stepIf.dirUp ? (stepIf.count == maxCount)
                              : (stepIf.count == puc_pkg::COUNT_MIN);
    stepIf.carryOutN = ~(atTerminal & ~stepIf.countInhibit);
  end

endmodule
`default_nettype wire

// ===== hw/puc_top.sv
// Top of the presettable up/down counter with its AHB-Lite register slave.
`default_nettype none
module puc_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        presetLoad,
  input  wire logic [3:0]  jamValue,
  input  wire logic        countInhibit,
  output logic             countBit0,
  output logic             countBit1,
  output logic             countBit2,
  output logic             countBit3,
  output logic             carryOutN,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic [1:0]       hresp
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  puc_step_if stepIf ();

  logic [3:0]       countReg;
  logic [3:0]       shownCount;
  logic             dirUp;
  logic             radixBinary;
  puc_pkg::puc_bus_e busState;
  puc_pkg::puc_bus_e next_busState;
  puc_pkg::puc_sel_e pendSel;
  logic             addrTaken;
  logic [31:0]      readValue;
  logic             ctrlWriteNow;

  // Only whole-word accesses are offered; the size is accepted but not decoded.
  logic [2:0]       unusedSize;
  assign unusedSize = hsize;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic puc_pkg::puc_sel_e decodeSel(input logic [31:0] addr);
    if (addr == puc_pkg::CTRL_OFFSET) begin
      decodeSel = puc_pkg::SEL_CTRL;
    end else if (addr == puc_pkg::STATUS_OFFSET) begin
      decodeSel = puc_pkg::SEL_STATUS;
    end else begin
      decodeSel = puc_pkg::SEL_NONE;
    end
  endfunction

  // ----------------------------------------------------------------
  // Step logic hookup
  // ----------------------------------------------------------------
  // The preset bypass makes the pins follow the jam inputs without waiting for an edge.
  assign shownCount = presetLoad ? jamValue : countReg;

  assign stepIf.count = shownCount;
  assign stepIf.dirUp = dirUp;
  assign stepIf.radixBinary = radixBinary;
  assign stepIf.countInhibit = countInhibit;

  puc_step u_step (
    .stepIf (stepIf)
  );

  // ----------------------------------------------------------------
  // Counter state
  // ----------------------------------------------------------------
  // Inhibit held low by the surrounding logic leaves clock and preset in control.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      countReg <= puc_pkg::COUNT_MIN;
    end else if (presetLoad) begin
      countReg <= jamValue;
    end else if (!countInhibit) begin
      countReg <= stepIf.nextCount;
    end else begin
      countReg <= countReg;
    end
  end

  // The count and carry pins are combinational: an edge would delay the preset and look-ahead.
  assign countBit0 = shownCount[0];
  assign countBit1 = shownCount[1];
  assign countBit2 = shownCount[2];
  assign countBit3 = shownCount[3];
  assign carryOutN = stepIf.carryOutN;

  // ----------------------------------------------------------------
  // Bus slave sequencing
  // ----------------------------------------------------------------
  assign addrTaken = hsel & hready & (htrans == puc_pkg::HTRANS_NONSEQ);

  always_comb begin
    if (addrTaken) begin
      next_busState = hwrite ? puc_pkg::BUS_WRITE : puc_pkg::BUS_READ;
    end else begin
      next_busState = puc_pkg::BUS_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busState <= puc_pkg::BUS_IDLE;
      pendSel  <= puc_pkg::SEL_NONE;
    end else begin
      busState <= next_busState;
      pendSel  <= addrTaken ? decodeSel(haddr) : puc_pkg::SEL_NONE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b0;
      hresp     <= puc_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= puc_pkg::HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_comb begin
    case (busState)
      puc_pkg::BUS_WRITE: begin
        ctrlWriteNow = (pendSel == puc_pkg::SEL_CTRL);
      end
      default: begin
        ctrlWriteNow = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dirUp       <= puc_pkg::CTRL_DIR_UP_RST;
      radixBinary <= puc_pkg::CTRL_BINARY_RST;
    end else if (ctrlWriteNow) begin
      dirUp       <= hwdata[puc_pkg::CTRL_DIR_UP_BIT];
      radixBinary <= hwdata[puc_pkg::CTRL_BINARY_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // A read right behind a control write sees the new value through forwarding.
  always_comb begin
    readValue = 32'h0000_0000;
    case (decodeSel(haddr))
      puc_pkg::SEL_CTRL: begin
        if (ctrlWriteNow) begin
          readValue[puc_pkg::CTRL_DIR_UP_BIT] = hwdata[puc_pkg::CTRL_DIR_UP_BIT];
          readValue[puc_pkg::CTRL_BINARY_BIT] = hwdata[puc_pkg::CTRL_BINARY_BIT];
        end else begin
          readValue[puc_pkg::CTRL_DIR_UP_BIT] = dirUp;
          readValue[puc_pkg::CTRL_BINARY_BIT] = radixBinary;
        end
      end
      puc_pkg::SEL_STATUS: begin
        readValue[puc_pkg::STATUS_COUNT_LSB +: puc_pkg::COUNT_W] = shownCount;
        readValue[puc_pkg::STATUS_CARRY_BIT] = stepIf.carryOutN;
        readValue[puc_pkg::STATUS_PRESET_BIT] = presetLoad;
        readValue[puc_pkg::STATUS_INHIBIT_BIT] = countInhibit;
      end
      default: begin
        readValue = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addrTaken && !hwrite) begin
      hrdata <= readValue;
    end
  end

endmodule
`default_nettype wire

// ===== sim/puc_top_chk.sv
// Port-level assertions of the up/down counter top.
`default_nettype none
module puc_top_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       presetLoad,
  input wire logic [3:0] jamValue,
  input wire logic       countInhibit,
  input wire logic       countBit0,
  input wire logic       countBit1,
  input wire logic       countBit2,
  input wire logic       countBit3,
  input wire logic       carryOutN,
  input wire logic       hreadyout,
  input wire logic [1:0] hresp
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [3:0] count = {countBit3, countBit2, countBit1, countBit0};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Counter and bus checks
  // ------------------------------------------------------------
  // Both cycles need preset low, or the bypass would hide the flop.
  sequence enabledEdge;
    !presetLoad && !countInhibit ##1 !presetLoad;
  endsequence
  sequence heldEdge;
    !presetLoad && countInhibit ##1 !presetLoad;
  endsequence
  preset_follow_a: assert property (presetLoad |-> count == jamValue)
    else $error("count differs from jam inputs");
  step_one_a: assert property (enabledEdge |-> count == $past(count) + 4'h1 ||
    count == $past(count) - 4'h1 || ($past(count) == 4'h9 && count == 4'h0) ||
    ($past(count) == 4'h0 && count == 4'h9) ||
    ($past(count) > 4'h9 && count inside {4'h0, 4'h9}))
    else $error("count did not move one step");
  hold_count_a: assert property (heldEdge |-> $stable(count))
    else $error("count moved while inhibited");
  carry_inhibit_a: assert property (countInhibit |-> carryOutN)
    else $error("carry low while inhibited");
  carry_term_a: assert property (!carryOutN |-> count inside {4'h0, 4'h9, 4'hf})
    else $error("carry low away from terminal count");
  carry_wrap_a: assert property (!carryOutN && !presetLoad ##1 !presetLoad |->
    (($past(count) == 4'h0) ? (count inside {4'h9, 4'hf}) : (count == 4'h0)))
    else $error("terminal count did not wrap");
  ready_high_a: assert property (!$past(rst) |-> hreadyout)
    else $error("slave inserted a wait state");
  resp_okay_a: assert property (hresp == puc_pkg::HRESP_OKAY)
    else $error("slave response not okay");
endmodule
bind puc_top puc_top_chk u_puc_top_chk (.clk(clk), .rst(rst), .presetLoad(presetLoad),
  .jamValue(jamValue), .countInhibit(countInhibit), .countBit0(countBit0),
  .countBit1(countBit1), .countBit2(countBit2), .countBit3(countBit3),
  .carryOutN(carryOutN), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// ===== sim/puc_stage_model.sv
// Behavioural next counter stage that counts on the block's carry.
`default_nettype none
module puc_stage_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       carryInN,
  output logic      [3:0] digit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shared clock: the upstream carry is this stage's enable, so no ripple delay.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      digit <= 4'h0;
    end else if (!carryInN) begin
      digit <= digit + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== sim/test_presettable_updown_counter.sv
// Self-checking bench of the up/down counter and its register slave.
`default_nettype none
module test_presettable_updown_counter;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, presetLoad, countInhibit, hsel, hwrite, hreadyout, carryOutN;
  logic        countBit0, countBit1, countBit2, countBit3;
  logic [1:0]  htrans, hresp;
  logic [3:0]  jamValue, digit;
  logic [31:0] haddr, hwdata, hrdata, rdWord;
  int          mismatches, checkCount;
  wire logic [3:0] count = {countBit3, countBit2, countBit1, countBit0};
  puc_top u_puc_top (.clk(clk), .rst(rst), .presetLoad(presetLoad), .jamValue(jamValue),
    .countInhibit(countInhibit), .countBit0(countBit0), .countBit1(countBit1),
    .countBit2(countBit2), .countBit3(countBit3), .carryOutN(carryOutN), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  puc_stage_model u_puc_stage_model (.clk(clk), .rst(rst), .carryInN(carryOutN),
    .digit(digit));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    if (mismatches == 0 && checkCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // A hung slave ends the run here instead of stalling it.
  task automatic waitReady();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 64);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic busXfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= puc_pkg::HTRANS_NONSEQ;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    rdWord = hrdata;
  endtask
  task automatic presetTo(input logic [3:0] v);
    @(posedge clk);
    presetLoad <= 1'b1;
    jamValue <= v;
    @(posedge clk);
    presetLoad <= 1'b0;
    countInhibit <= 1'b0;
  endtask
  task automatic regScn();
    logic [31:0] idleStatus;
    idleStatus = '0;
    idleStatus[puc_pkg::STATUS_CARRY_BIT] = 1'b1;
    idleStatus[puc_pkg::STATUS_INHIBIT_BIT] = 1'b1;
    busXfer(puc_pkg::CTRL_OFFSET, 1'b0, 32'h0);
    chkVal(rdWord, {30'h0, puc_pkg::CTRL_BINARY_RST, puc_pkg::CTRL_DIR_UP_RST});
    busXfer(puc_pkg::STATUS_OFFSET, 1'b0, 32'h0);
    chkVal(rdWord, idleStatus);
    busXfer(puc_pkg::CTRL_OFFSET, 1'b1, 32'hffff_fffe);
    busXfer(puc_pkg::CTRL_OFFSET, 1'b0, 32'h0);
    chkVal(rdWord, 32'h2);
    busXfer(puc_pkg::CTRL_OFFSET, 1'b1, 32'h3);
    busXfer(32'h0000_0008, 1'b1, 32'hffff_ffff);
    busXfer(32'h0000_0008, 1'b0, 32'h0);
    chkVal(rdWord, 32'h0);
    busXfer(puc_pkg::CTRL_OFFSET, 1'b0, 32'h0);
    chkVal(rdWord, 32'h3);
  endtask
  // A jammed digit above nine must step back into the decade range.
  task automatic rangeScn();
    @(posedge clk);
    countInhibit <= 1'b1;
    busXfer(puc_pkg::CTRL_OFFSET, 1'b1, 32'h1);
    presetTo(4'hc);
    @(negedge clk);
    chkVal(count, 32'hc);
    chkVal(carryOutN, 32'h1);
    @(negedge clk);
    chkVal(count, 32'h0);
    @(posedge clk);
    countInhibit <= 1'b1;
    busXfer(puc_pkg::CTRL_OFFSET, 1'b1, 32'h0);
    presetTo(4'hc);
    @(negedge clk);
    chkVal(count, 32'hc);
    @(negedge clk);
    chkVal(count, 32'h9);
  endtask
  task automatic presetScn();
    @(posedge clk);
    presetLoad <= 1'b1;
    jamValue <= 4'hf;
    @(negedge clk);
    chkVal(count, 32'hf);
    chkVal(carryOutN, 32'h1);
    @(posedge clk);
    presetLoad <= 1'b0;
    repeat (3) @(negedge clk);
    chkVal(count, 32'hf);
    @(posedge clk);
    countInhibit <= 1'b0;
    @(negedge clk);
    chkVal(carryOutN, 32'h0);
    @(negedge clk);
    chkVal(count, 32'h0);
  endtask
  task automatic modeScn(input logic up, input logic bin, input logic [3:0] start);
    logic [3:0] maxv;
    logic [3:0] exp;
    maxv = bin ? puc_pkg::BINARY_MAX : puc_pkg::DECADE_MAX;
    exp = start;
    @(posedge clk);
    countInhibit <= 1'b1;
    busXfer(puc_pkg::CTRL_OFFSET, 1'b1, {30'h0, bin, up});
    presetTo(start);
    repeat (12) begin
      @(negedge clk);
      chkVal(count, exp);
      chkVal(carryOutN, {31'h0, exp != (up ? maxv : puc_pkg::COUNT_MIN)});
      exp = up ? ((exp == maxv) ? puc_pkg::COUNT_MIN : exp + 4'h1)
               : ((exp == puc_pkg::COUNT_MIN) ? maxv : exp - 4'h1);
    end
  endtask
  task automatic cascadeScn();
    logic [3:0] d0;
    @(posedge clk);
    countInhibit <= 1'b1;
    busXfer(puc_pkg::CTRL_OFFSET, 1'b1, 32'h1);
    presetTo(4'h0);
    @(negedge clk);
    d0 = digit;
    repeat (25) @(negedge clk);
    chkVal(count, 32'h5);
    chkVal(4'(digit - d0), 32'h2);
  endtask
  initial begin
    rst = 1'b1;
    {presetLoad, hsel, hwrite, htrans, jamValue, haddr, hwdata} = '0;
    countInhibit = 1'b1;
    mismatches = 0;
    checkCount = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    regScn();
    presetScn();
    modeScn(1'b1, 1'b1, 4'he);
    modeScn(1'b0, 1'b1, 4'h1);
    modeScn(1'b1, 1'b0, 4'h8);
    modeScn(1'b0, 1'b0, 4'h1);
    rangeScn();
    cascadeScn();
    finish_test();
  end
endmodule
`default_nettype wire
